// ==== rtl/lcd_power_regs.vh ====
// Contract
// - Power bits: booster, regulator, follower enables
// - Display off masks power control outputs
// - Ratio command stores three low bits
// - Contrast mode accepts only value byte
// - Contrast value takes six low bits
// - Contrast mode ends after value stored
// - Indicator bit0 selects on or off
// - Indicator on locks until register byte
// - Indicator codes: off, fast, slow, steady
// - Indicator changed only by own commands and reset command
// - Indicator waveform between polarity and segment
// - Page blink is two byte command
// - Blink bit n enables page n
// - Drive mode selects four strengths
// - Drive mode in top bits, mode0 default
// - Reset command restores ratio, contrast, indicator
`ifndef LCD_POWER_REGS_VH
`define LCD_POWER_REGS_VH
// Command codes
`define CMD_DISP_OFF      8'hae
`define CMD_DISP_ON       8'haf
`define CMD_POWER_BASE    8'h28
`define CMD_POWER_MASK    8'hf8
`define CMD_RATIO_BASE    8'h20
`define CMD_RATIO_MASK    8'hf8
`define CMD_CONTRAST_MODE 8'h81
`define CMD_IND_OFF       8'hac
`define CMD_IND_ON        8'had
`define CMD_BLINK_MODE    8'ha5
`define CMD_DRIVE_MODE    8'hd2
`define CMD_RESET         8'he2
// Field positions
`define PWR_BOOST_BIT     2
`define PWR_REG_BIT       1
`define PWR_FOLLOW_BIT    0
// Reset values
`define RST_RATIO         3'h0
`define RST_CONTRAST      6'h20
`define RST_INDICATOR     2'h0
`define RST_BLINK         8'h00
`define RST_DRIVE         2'h0
`define RST_POWER         3'h0
// Timing: half-second and one-second blink periods
`define HALF_SEC_MS       500
`define ONE_SEC_MS        1000
`endif

// ==== rtl/blink_timer.v ====
`timescale 1ns/10ps
`include "lcd_power_regs.vh"
module blink_timer #(
  parameter CLK_HZ  = 100000000,
  parameter HALF_MS = `HALF_SEC_MS
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire arst_n,
  // Blink phases
  output reg  fastPhase,
  output reg  slowPhase
);
  localparam [31:0] TICKS = CLK_HZ / 1000 * HALF_MS;

  reg [31:0] count;

  // Divide the clock into half and one second toggles
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count     <= 32'h0;
      fastPhase <= 1'b0;
      slowPhase <= 1'b0;
    end else if (count >= TICKS - 32'h1) begin
      count     <= 32'h0;
      fastPhase <= ~fastPhase;
      if (fastPhase)
        slowPhase <= ~slowPhase;
    end else begin
      count <= count + 32'h1;
    end
  end
endmodule // blink_timer

// ==== rtl/lcd_power_cmd.v ====
`timescale 1ns/10ps
`include "lcd_power_regs.vh"
module lcd_power_cmd #(
  parameter CLK_HZ  = 100000000,
  parameter HALF_MS = `HALF_SEC_MS
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       arst_n,
  // Parallel bus pins
  input  wire [7:0] busData,
  input  wire       command_data_select,
  input  wire       read_write_select,
  input  wire       bus_strobe,
  input  wire       chipSelect_n,
  // Supply controls
  output reg        boosterOn,
  output reg        regulatorOn,
  output reg        followerOn,
  output reg  [2:0] resistorRatio,
  output reg  [5:0] contrastLevel,
  output reg  [1:0] driveMode,
  // Display status
  output reg        displayOn,
  output reg  [7:0] pageBlinkOut,
  // Static indicator
  output reg        frame_polarity_out,
  output reg        indicator_segment_out
);
  localparam ST_IDLE     = 3'h0;
  localparam ST_CONTRAST = 3'h1;
  localparam ST_IND      = 3'h2;
  localparam ST_PAGE     = 3'h3;
  localparam ST_DRIVE    = 3'h4;

  reg [7:0] dSync1;
  reg [7:0] dSync2;
  reg [3:0] cSync1;
  reg [3:0] cSync2;
  reg       strobeLast;
  reg [2:0] state;
  reg [2:0] powerEnables;
  reg [1:0] indicator_blink_select;
  reg [7:0] page_blink_enables;
  reg       indicatorLit;
  wire      fastPhase;
  wire      slowPhase;
  wire      strobeFall;
  wire      strobeGated;
  wire      cmdWrite;
  wire [7:0] cmd;

  // Two-stage synchronisers on all bus pins
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dSync1     <= 8'h00;
      dSync2     <= 8'h00;
      cSync1     <= 4'h0;
      cSync2     <= 4'h0;
      strobeLast <= 1'b0;
    end else begin
      dSync1     <= busData;
      dSync2     <= dSync1;
      cSync1     <= {command_data_select, read_write_select, bus_strobe, chipSelect_n};
      cSync2     <= cSync1;
      strobeLast <= strobeGated;
    end
  end

  // Command write taken on strobe falling edge with select, command_data_select and write low
  assign strobeGated = cSync2[1] | cSync2[0];
  assign strobeFall  = strobeLast & ~strobeGated;
  assign cmdWrite    = strobeFall & ~cSync2[3] & ~cSync2[2];
  assign cmd        = dSync2;

  // Command decoder with lockout states for double-byte commands
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state                  <= ST_IDLE;
      powerEnables           <= `RST_POWER;
      resistorRatio          <= `RST_RATIO;
      contrastLevel          <= `RST_CONTRAST;
      indicator_blink_select <= `RST_INDICATOR;
      page_blink_enables     <= `RST_BLINK;
      driveMode              <= `RST_DRIVE;
      displayOn              <= 1'b0;
    end else if (cmdWrite) begin
      case (state)
        ST_CONTRAST: begin
          contrastLevel <= cmd[5:0];
          state         <= ST_IDLE;
        end
        ST_IND: begin
          indicator_blink_select <= cmd[1:0];
          state                  <= ST_IDLE;
        end
        ST_PAGE: begin
          page_blink_enables <= cmd;
          state              <= ST_IDLE;
        end
        ST_DRIVE: begin
          if (cmd[5:0] == 6'h00)
            driveMode <= cmd[7:6];
          state <= ST_IDLE;
        end
        default: begin
          if ((cmd & `CMD_POWER_MASK) == `CMD_POWER_BASE)
            powerEnables <= cmd[2:0];
          else if ((cmd & `CMD_RATIO_MASK) == `CMD_RATIO_BASE)
            resistorRatio <= cmd[2:0];
          else if (cmd == `CMD_CONTRAST_MODE)
            state <= ST_CONTRAST;
          else if (cmd == `CMD_IND_OFF)
            indicator_blink_select <= 2'h0;
          else if (cmd == `CMD_IND_ON)
            state <= ST_IND;
          else if (cmd == `CMD_BLINK_MODE)
            state <= ST_PAGE;
          else if (cmd == `CMD_DRIVE_MODE)
            state <= ST_DRIVE;
          else if (cmd == `CMD_DISP_OFF)
            displayOn <= 1'b0;
          else if (cmd == `CMD_DISP_ON)
            displayOn <= 1'b1;
          else if (cmd == `CMD_RESET) begin
            resistorRatio          <= `RST_RATIO;
            contrastLevel          <= `RST_CONTRAST;
            indicator_blink_select <= `RST_INDICATOR;
          end
        end
      endcase
    end
  end

  // Supply outputs masked while display is off
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      boosterOn    <= 1'b0;
      regulatorOn  <= 1'b0;
      followerOn   <= 1'b0;
      pageBlinkOut <= 8'h00;
    end else begin
      boosterOn    <= displayOn & powerEnables[`PWR_BOOST_BIT];
      regulatorOn  <= displayOn & powerEnables[`PWR_REG_BIT];
      followerOn   <= displayOn & powerEnables[`PWR_FOLLOW_BIT];
      pageBlinkOut <= page_blink_enables & {8{fastPhase}};
    end
  end

  // Blink phase generator
  blink_timer #(
    .CLK_HZ  (CLK_HZ),
    .HALF_MS (HALF_MS)
  ) uTimer (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .fastPhase (fastPhase),
    .slowPhase (slowPhase)
  );

  // Lit decision from indicator register and blink phases only
  always @* begin
    case (indicator_blink_select)
      2'h1:    indicatorLit = fastPhase;
      2'h2:    indicatorLit = slowPhase;
      2'h3:    indicatorLit = 1'b1;
      default: indicatorLit = 1'b0;
    endcase
  end

  // Static drive: segment inverts polarity when lit
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_polarity_out    <= 1'b0;
      indicator_segment_out <= 1'b0;
    end else begin
      frame_polarity_out    <= slowPhase ^ fastPhase;
      indicator_segment_out <= (slowPhase ^ fastPhase) ^ indicatorLit;
    end
  end
endmodule // lcd_power_cmd

// ==== verification/lcd_power_monitor.sv ====
`timescale 1ns/10ps
module lcd_power_monitor (
  // Clock, reset and pins
  input wire       sys_clk, arst_n, command_data_select, read_write_select, bus_strobe,
  input wire       chipSelect_n, boosterOn, regulatorOn, followerOn, displayOn,
  input wire       frame_polarity_out, indicator_segment_out,
  input wire [7:0] busData, pageBlinkOut,
  input wire [2:0] resistorRatio,
  input wire [5:0] contrastLevel,
  input wire [1:0] driveMode
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // Settings move only after a selected command strobe
  chk_ratio_write: assert property ($changed(resistorRatio) |-> !$past(bus_strobe, 3)
    && !$past(command_data_select, 3) && !$past(chipSelect_n, 3)) else $error("ratio moved");
  chk_disp_write: assert property ($changed(displayOn) |-> !$past(command_data_select, 3))
    else $error("display moved");
  chk_ratio_value: assert property ($changed(resistorRatio) && resistorRatio != 3'h0
    |-> resistorRatio == $past(busData[2:0], 3)) else $error("ratio value");
  chk_contrast_value: assert property ($changed(contrastLevel) && contrastLevel != 6'h20
    |-> contrastLevel == $past(busData[5:0], 3)) else $error("contrast value");
  chk_contrast_alone: assert property ($changed(contrastLevel)
    |-> $stable(driveMode) && $stable(displayOn)) else $error("contrast not alone");
  chk_drive_low_zero: assert property ($changed(driveMode)
    |-> $past(busData[5:0], 3) == 6'h00) else $error("drive low bits");
  // Supply stages stay off while the display is off
  chk_power_mask: assert property (!displayOn |=> !boosterOn && !regulatorOn && !followerOn)
    else $error("power not masked");
  chk_power_rise: assert property ($rose(boosterOn) |-> displayOn)
    else $error("booster rose while off");
endmodule // lcd_power_monitor
bind lcd_power_cmd lcd_power_monitor u_mon (.*);

// ==== verification/lcd_host_model.sv ====
`timescale 1ns/10ps
module lcd_host_model (
  // Bus pins toward the device
  input  wire       sys_clk,
  output reg  [7:0] busData,
  output reg        command_data_select, read_write_select, bus_strobe, chipSelect_n
);
  // Idle bus
  initial begin
    {chipSelect_n, read_write_select, command_data_select, bus_strobe, busData} = 12'hf00;
  end
  // One write; pins held around the strobe, data inverted once released
  task wr(input a0, input [7:0] b);
    begin
      @(negedge sys_clk);
      {chipSelect_n, read_write_select, command_data_select, busData} = {2'b00, a0, b};
      repeat (3) @(negedge sys_clk);
      bus_strobe = 1'b0;
      repeat (4) @(negedge sys_clk);
      bus_strobe = 1'b1;
      repeat (4) @(negedge sys_clk);
      {chipSelect_n, read_write_select, busData} = {2'b11, ~b};
    end
  endtask
endmodule // lcd_host_model

// ==== verification/lcd_power_cmd_tb_top.sv ====
`timescale 1ns/10ps
module lcd_power_cmd_tb_top;
  reg        sys_clk = 1'b0;
  reg        arst_n  = 1'b0;
  wire [7:0] busData, pageBlinkOut;
  wire       command_data_select, read_write_select, bus_strobe, chipSelect_n;
  wire       boosterOn, regulatorOn, followerOn, displayOn;
  wire       frame_polarity_out, indicator_segment_out;
  wire [2:0] resistorRatio;
  wire [5:0] contrastLevel;
  wire [1:0] driveMode;
  wire [2:0] pwr = {boosterOn, regulatorOn, followerOn};
  integer    n_mismatch = 0;
  integer    checked    = 0;
  integer    i;
  // Clock and parts
  always #5 sys_clk = ~sys_clk;
  lcd_host_model u_host (.*);
  lcd_power_cmd #(.CLK_HZ(1000), .HALF_MS(4)) u_dut (.*);
  // Compare and count
  task chk(input string nm, input [7:0] s, input [7:0] e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task results;
    begin
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // Indicator electrodes differ (e=1) or agree over eight cycles
  task ind(input [7:0] e);
    repeat (8) @(negedge sys_clk) chk("indicator", frame_polarity_out ^ indicator_segment_out, e);
  endtask
  // Count lit/unlit changes over 32 cycles: fast blink 8, slow blink 4
  task blinks(input [7:0] e);
    reg     prev;
    integer n;
    begin
      n = 0;
      @(negedge sys_clk) prev = frame_polarity_out ^ indicator_segment_out;
      repeat (32) begin
        @(negedge sys_clk);
        if ((frame_polarity_out ^ indicator_segment_out) !== prev) n = n + 1;
        prev = frame_polarity_out ^ indicator_segment_out;
      end
      chk("blink changes", n[7:0], e);
    end
  endtask
  task t_power;
    begin
      chk("contrast reset", contrastLevel, 8'h20);
      u_host.wr(1'b0, 8'haf);
      u_host.wr(1'b0, 8'h2d);
      chk("power", pwr, 8'h05);
      u_host.wr(1'b0, 8'hae);
      chk("masked", pwr, 8'h00);
      u_host.wr(1'b0, 8'haf);
      u_host.wr(1'b0, 8'h2a);
      chk("power", pwr, 8'h02);
      $display("power done");
    end
  endtask
  task t_contrast;
    begin
      u_host.wr(1'b0, 8'h81);
      u_host.wr(1'b0, 8'hae);
      chk("contrast", contrastLevel, 8'h2e);
      chk("display", displayOn, 8'h01);
      u_host.wr(1'b0, 8'h27);
      chk("ratio", resistorRatio, 8'h07);
      u_host.wr(1'b1, 8'h23);
      chk("ratio", resistorRatio, 8'h07);
      u_host.wr(1'b0, 8'h23);
      chk("ratio", resistorRatio, 8'h03);
      $display("contrast done");
    end
  endtask
  task t_ind;
    begin
      u_host.wr(1'b0, 8'had);
      u_host.wr(1'b0, 8'h03);
      u_host.wr(1'b0, 8'hae);
      ind(8'h01);
      u_host.wr(1'b0, 8'hac);
      ind(8'h00);
      u_host.wr(1'b0, 8'had);
      u_host.wr(1'b0, 8'h81);
      chk("contrast", contrastLevel, 8'h2e);
      blinks(8'h08);
      u_host.wr(1'b0, 8'h25);
      chk("ratio", resistorRatio, 8'h05);
      u_host.wr(1'b0, 8'had);
      u_host.wr(1'b0, 8'h02);
      blinks(8'h04);
      $display("indicator done");
    end
  endtask
  task t_blink;
    begin
      u_host.wr(1'b0, 8'ha5);
      u_host.wr(1'b0, 8'h81);
      for (i = 0; i < 60 && pageBlinkOut === 8'h00; i = i + 1) @(negedge sys_clk);
      if (i == 60) begin
        n_mismatch = n_mismatch + 1;
        results;
      end
      chk("pages", pageBlinkOut, 8'h81);
      $display("blink done");
    end
  endtask
  task t_drive;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        u_host.wr(1'b0, 8'hd2);
        u_host.wr(1'b0, {i[1:0], 6'h00});
        chk("drive", driveMode, i[1:0]);
      end
      u_host.wr(1'b0, 8'hd2);
      u_host.wr(1'b0, 8'h41);
      chk("drive", driveMode, 8'h03);
      u_host.wr(1'b0, 8'he2);
      chk("contrast", contrastLevel, 8'h20);
      chk("ratio", resistorRatio, 8'h00);
      $display("drive done");
    end
  endtask
  // Main sequence
  initial begin
    repeat (4) @(negedge sys_clk);
    arst_n = 1'b1;
    t_power;
    t_contrast;
    t_ind;
    t_blink;
    t_drive;
    results;
  end
endmodule // lcd_power_cmd_tb_top
